/* File: hdl/mst_defs.svh */
// Constant definitions for the multimedia sync timer.
`ifndef MST_DEFS_SVH
`define MST_DEFS_SVH

// Counter geometry.
`define MST_COUNT_W 20
`define MST_COUNT_ZERO 20'h00000
`define MST_COUNT_ONE 20'h00001
`define MST_COUNT_MAX 20'hfffff
`define MST_HIGH_W 4

// Configuration space: the one byte that belongs to the timer.
`define MST_CFG_ADDR_W 8
`define MST_CFG_OFFSET 8'h64
`define MST_CFG_FAST_BIT 2
`define MST_CFG_SRST_BIT 1
`define MST_CFG_RESET 8'h00

// I/O window offsets.
`define MST_IO_ADDR_W 2
`define MST_IO_STATUS 2'h0
`define MST_IO_COUNT_LOW 2'h1
`define MST_IO_COUNT_MID 2'h2
`define MST_IO_COUNT_HIGH 2'h3

// Status and control field positions.
`define MST_ST_PRELOAD_BIT 3
`define MST_ST_RUN_BIT 2
`define MST_ST_FLAG_BIT 1
`define MST_ST_IRQEN_BIT 0
`define MST_STATUS_RESET 8'h00

// Data width and zero byte.
`define MST_DATA_W 8
`define MST_BYTE_ZERO 8'h00

// Tick timing: the resolution and the default oscillator rate.
`define MST_TICK_NS 1000
`define MST_NS_PER_US 1000
`define MST_HZ_PER_MHZ 1000000
`define MST_TIMEBASE_HZ_DEFAULT 4000000
`define MST_TIMEBASE_HZ_MAX 10000000
`define MST_SYNC_STAGES 2

`endif

/* File: hdl/mst_pkg.sv */
// Types shared by the multimedia sync timer modules.
`include "mst_defs.svh"

package mst_pkg;

   // Timer run state, one-hot.
   typedef enum logic [2:0]
   {
      MST_ST_HELD    = 3'b001,
      MST_ST_STOPPED = 3'b010,
      MST_ST_RUNNING = 3'b100
   } mst_run_e;

   // Complete state of the timer core.
   typedef struct packed
   {
      logic cfg_fast;
      logic cfg_srst;
      logic preload_select;
      logic run_enable;
      logic rollover_flag;
      logic rollover_irq_enable;
      logic [`MST_COUNT_W-1:0] count;
      logic [`MST_COUNT_W-1:0] preload;
      mst_run_e run_state;
      logic [`MST_DATA_W-1:0] rdata;
      logic rvalid;
      logic irq;
   } mst_core_s;

endpackage

/* File: hdl/mst_sync.sv */
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "mst_defs.svh"

module mst_sync
#(
   parameter int STAGES = `MST_SYNC_STAGES
)
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic async_i,
   output logic sync_o
);

   typedef struct packed
   {
      logic [STAGES-1:0] chain;
   } mst_sync_s;

   mst_sync_s st;
   mst_sync_s next_st;

   generate
      if (STAGES < 2)
      begin : g_check
         $error("mst_sync needs at least two stages");
      end
   endgenerate

   // Only the next stage reads each flop; the last one is the output.
   always_comb
   begin
      next_st = st;
      next_st.chain = {st.chain[STAGES-2:0], async_i};
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         st <= '0;
      else
         st <= next_st;
   end

   assign sync_o = st.chain[STAGES-1];

endmodule
`default_nettype wire

/* File: hdl/mst_tick_div.sv */
// Microsecond tick generator dividing the synchronised oscillator clock.
`timescale 1ns/1ps
`default_nettype none
`include "mst_defs.svh"

module mst_tick_div
#(
   parameter int TIMEBASE_HZ = `MST_TIMEBASE_HZ_DEFAULT
)
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic clear_i,
   input wire logic timebase_level_i,
   output logic tick_o
);

   // Oscillator rising edges per microsecond tick.
   localparam int DIV = (TIMEBASE_HZ / `MST_HZ_PER_MHZ) * `MST_TICK_NS / `MST_NS_PER_US;
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   typedef struct packed
   {
      logic prev;
      logic [CW-1:0] cnt;
      logic tick;
   } mst_div_s;

   mst_div_s st;
   mst_div_s next_st;

   // The oscillator is sampled, so it must stay below half of mclk.
   generate
      if (DIV < 1 || TIMEBASE_HZ > `MST_TIMEBASE_HZ_MAX || (TIMEBASE_HZ % `MST_HZ_PER_MHZ) != 0)
      begin : g_check
         $error("mst_tick_div: TIMEBASE_HZ must be whole MHz, 1 to 10 MHz");
      end
   endgenerate

   always_comb
   begin
      next_st = st;
      next_st.prev = timebase_level_i;
      next_st.tick = 1'b0;
      if (clear_i)
      begin
         next_st.cnt = '0;
      end
      else if (timebase_level_i && !st.prev)
      begin
         if (st.cnt == LAST)
         begin
            next_st.cnt = '0;
            next_st.tick = 1'b1;
         end
         else
         begin
            next_st.cnt = st.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         st <= '0;
      else
         st <= next_st;
   end

   assign tick_o = st.tick;

endmodule
`default_nettype wire

/* File: hdl/mst_timer.sv */
// Multimedia sync timer: 20-bit microsecond counter with its byte registers.
`timescale 1ns/1ps
`default_nettype none
`include "mst_defs.svh"

// Function
// R1: Twenty-bit counter advancing once per microsecond tick in normal use.
// R2: Microsecond tick comes from dividing the oscillator clock, not the bus clock.
// R3: Software uses byte-wide accesses only.
// R4: Control byte sits at configuration offset 64h; others in the I/O window.
// R5: With fast tick select set, count advances on every bus clock.
// R6: While the soft reset bit is set, the whole timer stays reset; the configuration byte and read data keep their values.
// R7: System reset clears the timer, its count and its status.
// R8: Reserved bits read as zero.
// R9: Preload select starts counting from the written value, else from held value.
// R10: Run enable resumes at the next tick edge; clearing it holds the count.
// R11: Wrapping to zero sets the rollover flag; counting continues.
// R12: Writing one clears the rollover flag; writing zero leaves it.
// R13: Interrupt only while rollover interrupt enable is set.
// R14: Count bytes sit at I/O offsets 01h, 02h and low nibble of 03h.
// R15: Count registers are writable to load a preload start value.
// R16: Software reads the full count in three byte cycles.
// R17: Software should read the low count byte first.
// R18: Count increments by one and wraps from all ones to zero.
// R19: Interrupt asserted while rollover flag and its enable are both set.
module mst_timer
#(
   parameter int TIMEBASE_HZ = `MST_TIMEBASE_HZ_DEFAULT
)
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic oscillator_clock_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [`MST_CFG_ADDR_W-1:0] cfg_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [`MST_IO_ADDR_W-1:0] io_addr_i,
   input wire logic [`MST_DATA_W-1:0] wdata_i,
   output logic [`MST_DATA_W-1:0] rdata_o,
   output logic rvalid_o,
   output logic timer_irq_o
);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------

   // The divider counts whole oscillator edges, so only whole megahertz rates work.
   generate
      if (TIMEBASE_HZ < `MST_HZ_PER_MHZ || TIMEBASE_HZ > `MST_TIMEBASE_HZ_MAX ||
         (TIMEBASE_HZ % `MST_HZ_PER_MHZ) != 0)
      begin : g_check
         $error("mst_timer: TIMEBASE_HZ must be whole MHz, 1 to 10 MHz");
      end
   endgenerate

   // Reset images of the two control bytes; each field takes its own bit.
   localparam logic [`MST_DATA_W-1:0] CFG_RESET = `MST_CFG_RESET;
   localparam logic [`MST_DATA_W-1:0] STATUS_RESET = `MST_STATUS_RESET;

   // ----------------------------------------------------------------
   // Oscillator tick
   // ----------------------------------------------------------------

   logic timebase_level;
   logic us_tick;
   mst_pkg::mst_core_s st;
   mst_pkg::mst_core_s next_st;

   mst_sync u_timebase_sync
   (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(oscillator_clock_i),
      .sync_o(timebase_level)
   );

   // The divider is held cleared with the timer so a release starts a
   // full microsecond, not a fragment of one.
   mst_tick_div #(.TIMEBASE_HZ(TIMEBASE_HZ)) u_tick_div // see R2
   (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .clear_i(st.cfg_srst),
      .timebase_level_i(timebase_level),
      .tick_o(us_tick)
   );

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------

   // True when the I/O address selects the given register.
   function automatic logic io_hit
   (
      input logic [`MST_IO_ADDR_W-1:0] addr,
      input logic [`MST_IO_ADDR_W-1:0] offset
   );
      io_hit = (addr == offset);
   endfunction

   // Status byte image with reserved bits forced low.
   function automatic logic [`MST_DATA_W-1:0] status_image
   (
      input mst_pkg::mst_core_s s
   );
      logic [`MST_DATA_W-1:0] b;
      b = `MST_BYTE_ZERO;
      b[`MST_ST_PRELOAD_BIT] = s.preload_select;
      b[`MST_ST_RUN_BIT] = s.run_enable;
      b[`MST_ST_FLAG_BIT] = s.rollover_flag;
      b[`MST_ST_IRQEN_BIT] = s.rollover_irq_enable;
      status_image = b;
   endfunction

   // Configuration byte image with reserved bits forced low.
   function automatic logic [`MST_DATA_W-1:0] config_image
   (
      input mst_pkg::mst_core_s s
   );
      logic [`MST_DATA_W-1:0] b;
      b = `MST_BYTE_ZERO;
      b[`MST_CFG_FAST_BIT] = s.cfg_fast;
      b[`MST_CFG_SRST_BIT] = s.cfg_srst;
      config_image = b;
   endfunction

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------

   always_comb
   begin
      logic cfg_sel;
      logic count_step;
      logic wrap;
      logic flag_clear;
      logic start;
      logic [`MST_COUNT_W-1:0] pre;
      logic [`MST_DATA_W-1:0] rd;

      next_st = st;
      cfg_sel = (cfg_addr_i == `MST_CFG_OFFSET); // see R4
      count_step = 1'b0;
      wrap = 1'b0;
      flag_clear = 1'b0;
      start = 1'b0;
      pre = st.preload;
      rd = `MST_BYTE_ZERO;

      // Configuration byte: not cleared by its own soft reset bit.
      if (cfg_wr_i && cfg_sel)
      begin
         next_st.cfg_fast = wdata_i[`MST_CFG_FAST_BIT]; // see R5
         next_st.cfg_srst = wdata_i[`MST_CFG_SRST_BIT]; // see R6
      end

      // Software writes to the I/O window; byte wide by construction.
      if (io_wr_i && !st.cfg_srst) // see R3
      begin
         if (io_hit(io_addr_i, `MST_IO_STATUS))
         begin
            next_st.preload_select = wdata_i[`MST_ST_PRELOAD_BIT]; // see R9
            next_st.run_enable = wdata_i[`MST_ST_RUN_BIT]; // see R10
            next_st.rollover_irq_enable = wdata_i[`MST_ST_IRQEN_BIT]; // see R13
            flag_clear = wdata_i[`MST_ST_FLAG_BIT]; // see R12
         end
         if (io_hit(io_addr_i, `MST_IO_COUNT_LOW))
         begin
            pre[7:0] = wdata_i; // see R14
         end
         if (io_hit(io_addr_i, `MST_IO_COUNT_MID))
         begin
            pre[15:8] = wdata_i; // see R14
         end
         if (io_hit(io_addr_i, `MST_IO_COUNT_HIGH))
         begin
            pre[19:16] = wdata_i[`MST_HIGH_W-1:0]; // see R14
         end
         next_st.preload = pre; // see R15
      end

      // Fast mode replaces the microsecond tick by every bus clock.
      count_step = st.cfg_fast ? 1'b1 : us_tick; // see R1, R5

      case (st.run_state)
         mst_pkg::MST_ST_HELD:
         begin
            if (!st.cfg_srst)
               next_st.run_state = mst_pkg::MST_ST_STOPPED;
         end
         mst_pkg::MST_ST_STOPPED:
         begin
            // The start waits for a tick edge, which also loads the preload when preload select is set.
            if (st.run_enable && count_step) // see R10
            begin
               start = 1'b1;
               next_st.run_state = mst_pkg::MST_ST_RUNNING;
            end
         end
         mst_pkg::MST_ST_RUNNING:
         begin
            if (!st.run_enable) // see R10
               next_st.run_state = mst_pkg::MST_ST_STOPPED;
            else if (count_step)
            begin
               wrap = (st.count == `MST_COUNT_MAX); // see R11, R18
               next_st.count = st.count + `MST_COUNT_ONE; // see R18
            end
         end
         default:
         begin
            next_st.run_state = mst_pkg::MST_ST_HELD;
         end
      endcase

      // Preload applies at the start tick; otherwise the held count goes on.
      if (start && st.preload_select)
      begin
         next_st.count = st.preload; // see R9
      end

      // A wrap in the cycle of a clear keeps the flag set, so a rollover
      // that lands on the clear is never lost.
      next_st.rollover_flag = (st.rollover_flag && !flag_clear) || wrap; // see R11, R12

      // Read data is registered; unmapped addresses read as zero.
      // The bytes are not latched together, so a carry between two byte reads
      // can tear the value; reading the low byte first keeps the error smallest.
      if (io_rd_i)
      begin
         if (io_hit(io_addr_i, `MST_IO_STATUS))
            rd = status_image(st); // see R8
         else if (io_hit(io_addr_i, `MST_IO_COUNT_LOW))
            rd = st.count[7:0]; // see R14, R16, R17
         else if (io_hit(io_addr_i, `MST_IO_COUNT_MID))
            rd = st.count[15:8]; // see R14
         else
            rd = {4'h0, st.count[19:16]}; // see R8, R14
      end
      else if (cfg_rd_i && cfg_sel)
      begin
         rd = config_image(st); // see R8
      end
      next_st.rdata = rd;
      next_st.rvalid = io_rd_i || cfg_rd_i;

      // Soft reset overrides every timer field but the configuration byte and the read data.
      if (st.cfg_srst) // see R6
      begin
         next_st.preload_select = 1'b0;
         next_st.run_enable = 1'b0;
         next_st.rollover_flag = 1'b0;
         next_st.rollover_irq_enable = 1'b0;
         next_st.count = `MST_COUNT_ZERO;
         next_st.preload = `MST_COUNT_ZERO;
         next_st.run_state = mst_pkg::MST_ST_HELD;
      end

      next_st.irq = next_st.rollover_flag && next_st.rollover_irq_enable; // see R13, R19
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i) // see R7
      begin
         st.cfg_fast <= CFG_RESET[`MST_CFG_FAST_BIT];
         st.cfg_srst <= CFG_RESET[`MST_CFG_SRST_BIT];
         st.preload_select <= STATUS_RESET[`MST_ST_PRELOAD_BIT];
         st.run_enable <= STATUS_RESET[`MST_ST_RUN_BIT];
         st.rollover_flag <= STATUS_RESET[`MST_ST_FLAG_BIT];
         st.rollover_irq_enable <= STATUS_RESET[`MST_ST_IRQEN_BIT];
         st.count <= `MST_COUNT_ZERO;
         st.preload <= `MST_COUNT_ZERO;
         st.run_state <= mst_pkg::MST_ST_STOPPED;
         st.rdata <= `MST_BYTE_ZERO;
         st.rvalid <= 1'b0;
         st.irq <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   assign rdata_o = st.rdata;
   assign rvalid_o = st.rvalid;
   assign timer_irq_o = st.irq;

endmodule
`default_nettype wire

/* File: verif/mst_timer_monitor.sv */
// Concurrent checks on the timer's register port and interrupt output.
`timescale 1ns/1ps
`default_nettype none

module mst_timer_monitor
#(
   parameter int TIMEBASE_HZ = 4000000
)
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic oscillator_clock_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [1:0] io_addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic timer_irq_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_read_answer: assert property ((io_rd_i || cfg_rd_i) |=> rvalid_o)
      else $error("read strobe without answer");
   a_no_stray: assert property (!(io_rd_i || cfg_rd_i) |=> !rvalid_o)
      else $error("answer without read strobe");
   a_idle_zero: assert property (!rvalid_o |-> rdata_o == 8'h00)
      else $error("read data not zero while idle");
   a_cfg_reserved: assert property (cfg_rd_i && !io_rd_i && cfg_addr_i == 8'h64 |=> rdata_o[7:3] == 5'h00 && !rdata_o[0])
      else $error("config reserved bits not zero");
   a_cfg_unmapped: assert property (cfg_rd_i && !io_rd_i && cfg_addr_i != 8'h64 |=> rdata_o == 8'h00)
      else $error("unmapped config read not zero");
   a_stat_reserved: assert property (io_rd_i && io_addr_i == 2'h0 |=> rdata_o[7:4] == 4'h0)
      else $error("status reserved bits not zero");
   a_high_reserved: assert property (io_rd_i && io_addr_i == 2'h3 |=> rdata_o[7:4] == 4'h0)
      else $error("count high reserved bits not zero");
   a_irq_status: assert property (io_rd_i && io_addr_i == 2'h0 |=> $past(timer_irq_o) == (rdata_o[1] & rdata_o[0]))
      else $error("interrupt disagrees with flag and enable");
   a_reset_quiet: assert property ($fell(sys_rst_i) |-> !rvalid_o && !timer_irq_o && rdata_o == 8'h00)
      else $error("outputs not cleared by reset");
endmodule

`default_nettype wire

/* File: verif/mst_timer_tb_top.sv */
// Self-checking testbench for the multimedia sync timer.
`timescale 1ns/1ps
`default_nettype none

module mst_timer_tb_top;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic oscillator_clock_i = 1'b0;
   logic cfg_wr_i = 1'b0;
   logic cfg_rd_i = 1'b0;
   logic [7:0] cfg_addr_i = 8'h00;
   logic io_wr_i = 1'b0;
   logic io_rd_i = 1'b0;
   logic [1:0] io_addr_i = 2'h0;
   logic [7:0] wdata_i = 8'h00;
   logic [7:0] rdata_o;
   logic rvalid_o;
   logic timer_irq_o;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   logic [7:0] q;
   logic [7:0] h;

   mst_timer #(.TIMEBASE_HZ(1000000)) i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .oscillator_clock_i(oscillator_clock_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
      .cfg_addr_i(cfg_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
      .io_addr_i(io_addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .timer_irq_o(timer_irq_o));

   always #25 mclk_i = ~mclk_i;

   // The oscillator is offset so that its edges never meet the bus clock's.
   initial
   begin
      #13;
      forever #500 oscillator_clock_i = ~oscillator_clock_i;
   end

   // ---------------------------------------------------------------
   // Access and compare tasks
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic acc(input logic c, input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      #1;
      cfg_wr_i = c & w;
      cfg_rd_i = c & ~w;
      io_wr_i = ~c & w;
      io_rd_i = ~c & ~w;
      cfg_addr_i = a;
      io_addr_i = a[1:0];
      wdata_i = d;
      @(posedge mclk_i);
      #1;
      {cfg_wr_i, cfg_rd_i, io_wr_i, io_rd_i} = 4'h0;
      q = rdata_o;
      if (!w)
         chk("rvalid", 8'h01, {7'h00, rvalid_o});
   endtask

   task automatic rdc(input logic c, input logic [7:0] a, input logic [7:0] e);
      acc(c, 1'b0, a, 8'h00);
      chk($sformatf("reg_%h", a), e, q);
   endtask

   task automatic t_zero_regs();
      rdc(1'b1, 8'h64, 8'h00);
      for (int i = 0; i < 4; i++)
         rdc(1'b0, 8'(i), 8'h00);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_config();
      acc(1'b1, 1'b1, 8'h64, 8'hff);
      rdc(1'b1, 8'h64, 8'h06);
      acc(1'b1, 1'b1, 8'h65, 8'hff);
      rdc(1'b1, 8'h65, 8'h00);
      acc(1'b1, 1'b1, 8'h64, 8'h04);
   endtask

   // Preload just below the wrap so the count rolls over during the reads.
   task automatic t_fast_wrap();
      acc(1'b0, 1'b1, 8'h01, 8'hfc);
      acc(1'b0, 1'b1, 8'h02, 8'hff);
      acc(1'b0, 1'b1, 8'h03, 8'hff);
      acc(1'b0, 1'b1, 8'h00, 8'h0d);
      rdc(1'b0, 8'h01, 8'hfc);
      rdc(1'b0, 8'h02, 8'hff);
      rdc(1'b0, 8'h03, 8'h00);
      rdc(1'b0, 8'h00, 8'h0f);
      chk("irq", 8'h01, {7'h00, timer_irq_o});
   endtask

   task automatic t_flag();
      logic [7:0] wv [3] = '{8'h0c, 8'h0d, 8'h0f};
      logic [7:0] sv [3] = '{8'h0e, 8'h0f, 8'h0d};
      for (int i = 0; i < 3; i++)
      begin
         acc(1'b0, 1'b1, 8'h00, wv[i]);
         rdc(1'b0, 8'h00, sv[i]);
         chk("irq", {7'h00, sv[i][1] & sv[i][0]}, {7'h00, timer_irq_o});
      end
   endtask

   task automatic t_hold_resume();
      acc(1'b0, 1'b1, 8'h00, 8'h00);
      acc(1'b0, 1'b0, 8'h01, 8'h00);
      h = q;
      repeat (5) @(posedge mclk_i);
      rdc(1'b0, 8'h01, h);
      acc(1'b0, 1'b1, 8'h00, 8'h04);
      rdc(1'b0, 8'h01, h);
      rdc(1'b0, 8'h01, h + 8'h02);
   endtask

   task automatic t_soft_reset();
      acc(1'b1, 1'b1, 8'h64, 8'h06);
      acc(1'b0, 1'b1, 8'h01, 8'h55);
      rdc(1'b0, 8'h00, 8'h00);
      rdc(1'b0, 8'h01, 8'h00);
      rdc(1'b1, 8'h64, 8'h06);
      acc(1'b1, 1'b1, 8'h64, 8'h00);
      rdc(1'b0, 8'h00, 8'h00);
      rdc(1'b0, 8'h01, 8'h00);
   endtask

   // Ten microseconds of slow ticks must give about nine counts, not two hundred.
   task automatic t_slow_tick();
      acc(1'b0, 1'b1, 8'h00, 8'h04);
      repeat (200) @(posedge mclk_i);
      acc(1'b0, 1'b1, 8'h00, 8'h00);
      acc(1'b0, 1'b0, 8'h01, 8'h00);
      chk("tick_rate", 8'h01, {7'h00, q >= 8'h08 && q <= 8'h0b});
      rdc(1'b0, 8'h02, 8'h00);
   endtask

   task automatic t_sys_reset();
      acc(1'b1, 1'b1, 8'h64, 8'h04);
      acc(1'b0, 1'b1, 8'h00, 8'h05);
      repeat (20) @(posedge mclk_i);
      #1;
      sys_rst_i = 1'b1;
      repeat (6) @(posedge mclk_i);
      #1;
      sys_rst_i = 1'b0;
      t_zero_regs();
   endtask

   // ---------------------------------------------------------------
   // Sequence and closing
   // ---------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         summarize();
      end
   end

   initial
   begin
      repeat (6) @(posedge mclk_i);
      #1;
      sys_rst_i = 1'b0;
      t_zero_regs();
      t_config();
      t_fast_wrap();
      t_flag();
      t_hold_resume();
      t_soft_reset();
      t_slow_tick();
      t_sys_reset();
      summarize();
   end
endmodule

bind mst_timer mst_timer_monitor #(.TIMEBASE_HZ(TIMEBASE_HZ)) i_mon (.mclk_i(mclk_i),
   .sys_rst_i(sys_rst_i), .oscillator_clock_i(oscillator_clock_i),
   .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
   .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_addr_i(io_addr_i),
   .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
   .timer_irq_o(timer_irq_o));

`default_nettype wire
